// ===== power_state_wake_control_test.sv
`timescale 1ns/100ps
module power_state_wake_control_test;
    import pswc_pkg::*;
    logic clk, rstn, chassis, clr, s5En, pwrSw, pwrOn, fan, intr, wakeEv;
    logic rtc, pcie, lan, pme, ps2, ser, usb;
    pswc_req_t req;
    pswc_state_t st;
    int errors = 0;
    int n_compared = 0;
    pswc_top #(.LONG_CYC(50), .DEB_CYC(3)) u_dut (.clk(clk), .rstn(rstn),
        .pwrSwitchPressed(pwrSw), .chassisClosed(chassis),
        .rtcAlarm(rtc), .pcieWake(pcie), .lanWake(lan),
        .pmeWake(pme), .ps2Wake(ps2), .serialWake(ser),
        .usbWake(usb), .s5WakeEnable(s5En), .osSleepReq(req),
        .intrusionClear(clr), .powerState(st), .sysPowerOn(pwrOn),
        .fanOn(fan), .intrusionFlag(intr), .wakeEvent(wakeEv));
    pswc_panel u_panel (.clk(clk), .pwrSwitchPressed(pwrSw));
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    task chk(logic [2:0] s, logic [2:0] e);
        n_compared++;
        if (s !== e) begin
            errors++;
            $display("MISMATCH %0t got %0h exp %0h", $time, s, e);
        end
    endtask
    task step(logic [6:0] w, pswc_req_t r, pswc_state_t e);
        @(negedge clk);
        {usb, ser, ps2, pme, lan, pcie, rtc} = w;
        req = r;
        @(negedge clk);
        {usb, ser, ps2, pme, lan, pcie, rtc} = '0;
        req = REQ_NONE;
        chk(st, e);
        chk(wakeEv, w != 0 && e == PS_S0);
        chk(pwrOn, e == PS_S0);
        chk(fan, e == PS_S0);
        @(negedge clk);
        chk(wakeEv, 1'b0);
    endtask
    task check_idle;
        chk(st, PS_S5);
        chk(pwrOn, 1'b0);
        chk(fan, 1'b0);
        chk(intr, 1'b0);
        chk(wakeEv, 1'b0);
    endtask
    task complete_run;
        $display("compared %0d mismatches %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    task test_switch;
        u_panel.press(10);
        chk(st, PS_S0);
        chk(pwrOn, 1'b1);
        u_panel.press(49);
        chk(st, PS_S3);
        chk(fan, 1'b0);
        u_panel.press(10);
        chk(st, PS_S0);
        u_panel.press(50);
        chk(st, PS_S5);
        u_panel.press(10);
        chk(st, PS_S0);
        u_panel.press(10);
        chk(st, PS_S3);
        u_panel.press(70);
        chk(st, PS_S5);
        u_panel.press(70);
        chk(st, PS_S5);
        $display("switch test done");
    endtask
    task test_wake;
        step(7'h01, REQ_NONE, PS_S0);
        step(7'h00, REQ_S4, PS_S4);
        step(7'h70, REQ_NONE, PS_S4);
        step(7'h08, REQ_NONE, PS_S0);
        step(7'h00, REQ_S3, PS_S3);
        step(7'h40, REQ_NONE, PS_S0);
        step(7'h00, REQ_S3, PS_S3);
        step(7'h10, REQ_NONE, PS_S0);
        step(7'h00, REQ_S3, PS_S3);
        step(7'h20, REQ_NONE, PS_S0);
        step(7'h00, REQ_S3, PS_S3);
        step(7'h04, REQ_NONE, PS_S0);
        step(7'h00, REQ_S3, PS_S3);
        step(7'h08, REQ_NONE, PS_S0);
        step(7'h00, REQ_S3, PS_S3);
        step(7'h01, REQ_NONE, PS_S0);
        step(7'h00, REQ_S3, PS_S3);
        step(7'h00, REQ_S5, PS_S3);
        step(7'h02, REQ_NONE, PS_S0);
        step(7'h00, REQ_S4, PS_S4);
        step(7'h04, REQ_NONE, PS_S0);
        step(7'h00, REQ_S4, PS_S4);
        step(7'h01, REQ_NONE, PS_S0);
        step(7'h00, REQ_S4, PS_S4);
        step(7'h02, REQ_NONE, PS_S0);
        step(7'h00, REQ_S5, PS_S5);
        step(7'h70, REQ_NONE, PS_S5);
        step(7'h0c, REQ_NONE, PS_S5);
        step(7'h02, REQ_NONE, PS_S0);
        step(7'h00, REQ_S5, PS_S5);
        s5En = 1'b1;
        step(7'h04, REQ_NONE, PS_S0);
        step(7'h00, REQ_S5, PS_S5);
        step(7'h08, REQ_NONE, PS_S0);
        $display("wake test done");
    endtask
    task test_reset;
        chk(st, PS_S0);
        rstn = 1'b0;
        @(negedge clk);
        check_idle;
        rstn = 1'b1;
        @(negedge clk);
        @(negedge clk);
        check_idle;
        $display("reset test done");
    endtask
    task test_intrusion;
        chassis = 1'b1;
        @(negedge clk) chassis = 1'b0;
        repeat (8) @(negedge clk);
        chk(intr, 1'b0);
        chassis = 1'b1;
        repeat (10) @(negedge clk);
        chk(intr, 1'b1);
        chassis = 1'b0;
        repeat (8) @(negedge clk);
        chk(intr, 1'b1);
        chassis = 1'b1;
        repeat (10) @(negedge clk);
        clr = 1'b1;
        repeat (3) @(negedge clk);
        chk(intr, 1'b1);
        chassis = 1'b0;
        repeat (8) @(negedge clk);
        chk(intr, 1'b0);
        clr = 1'b0;
        $display("intrusion test done");
    endtask
    initial begin
        {rstn, chassis, clr, s5En} = '0;
        {usb, ser, ps2, pme, lan, pcie, rtc} = '0;
        req = REQ_NONE;
        repeat (20) @(negedge clk);
        rstn = 1'b1;
        check_idle;
        test_switch;
        test_wake;
        test_reset;
        test_intrusion;
        complete_run;
    end
    initial begin
        repeat (3000) @(posedge clk);
        errors++;
        complete_run;
    end
endmodule

// ===== pswc_debounce.sv
`timescale 1ns/100ps
module pswc_debounce #(
    parameter int unsigned STABLE_CYC = 200_000
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic rawIn,
    output logic cleanOut
);
    localparam int CW = $clog2(STABLE_CYC + 1);

    logic sync1_q, sync1_d, sync2_q, sync2_d;
    logic clean_q, clean_d;
    logic [CW-1:0] cnt_q, cnt_d;

    // Two-stage synchroniser, then a stability counter
    always_comb begin
        sync1_d = rawIn;
        sync2_d = sync1_q;
        clean_d = clean_q;
        cnt_d = cnt_q;
        if (sync2_q == clean_q) begin
            cnt_d = '0;
        end else if (cnt_q == CW'(STABLE_CYC - 1)) begin
            cnt_d = '0;
            clean_d = sync2_q;
        end else begin
            cnt_d = cnt_q + 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            sync1_q <= 1'b0;
            sync2_q <= 1'b0;
            clean_q <= 1'b0;
            cnt_q <= '0;
        end else begin
            sync1_q <= sync1_d;
            sync2_q <= sync2_d;
            clean_q <= clean_d;
            cnt_q <= cnt_d;
        end
    end

    assign cleanOut = clean_q;
endmodule

// ===== pswc_panel.sv
`timescale 1ns/100ps
module pswc_panel (
    input wire logic clk,
    output logic pwrSwitchPressed
);
    initial pwrSwitchPressed = 1'b0;
    // Bouncy press; open switch reads low
    task automatic press(int n);
        repeat (2) begin
            @(negedge clk) pwrSwitchPressed = 1'b1;
            @(negedge clk) pwrSwitchPressed = 1'b0;
        end
        @(negedge clk) pwrSwitchPressed = 1'b1;
        repeat (n) @(negedge clk);
        pwrSwitchPressed = 1'b0;
        repeat (12) @(negedge clk);
    endtask
endmodule

// ===== pswc_pkg.sv
package pswc_pkg;
    // Power states of the system
    typedef enum logic [2:0] {
        PS_S0,
        PS_S3,
        PS_S4,
        PS_S5
    } pswc_state_t;

    // Sleep request codes from the operating system
    typedef enum logic [1:0] {
        REQ_NONE,
        REQ_S3,
        REQ_S4,
        REQ_S5
    } pswc_req_t;

    localparam int unsigned CLK_HZ = 20_000_000;
    localparam int unsigned LONG_PRESS_MS = 4000;
    localparam int unsigned LONG_PRESS_CYC = CLK_HZ / 1000 * LONG_PRESS_MS;
    localparam int unsigned DEBOUNCE_US = 10000;
    localparam int unsigned DEBOUNCE_CYC = CLK_HZ / 1000_000 * DEBOUNCE_US;
    localparam logic RST_S5_WAKE_EN = 1'b0;
    localparam logic RST_FAN_ON = 1'b0;
    localparam pswc_state_t RST_STATE = PS_S5;
    localparam logic RST_PWR_ON = 1'b0;
    localparam logic RST_INTR = 1'b0;
    localparam logic RST_WAKE = 1'b0;
endpackage

// ===== pswc_top.sv
`timescale 1ns/100ps
// Overview of operation
// - Short press: off to on, on-sleep toggle
// - Long press forces soft-off from on/sleep
// - Switch, RTC, PCIe wake from S3-S5
// - PS/2, serial, USB wake only S3
// - LAN/PME wake S3,S4; S5 if enabled
// - Closed chassis switch records intrusion
// - Software soft-off without the switch
// - Fans on only in S0
module pswc_top
    import pswc_pkg::*;
#(
    parameter int unsigned LONG_CYC = pswc_pkg::LONG_PRESS_CYC,
    parameter int unsigned DEB_CYC = pswc_pkg::DEBOUNCE_CYC
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic pwrSwitchPressed,
    input wire logic chassisClosed,
    input wire logic rtcAlarm,
    input wire logic pcieWake,
    input wire logic lanWake,
    input wire logic pmeWake,
    input wire logic ps2Wake,
    input wire logic serialWake,
    input wire logic usbWake,
    input wire logic s5WakeEnable,
    input wire pswc_pkg::pswc_req_t osSleepReq,
    input wire logic intrusionClear,
    output pswc_pkg::pswc_state_t powerState,
    output logic sysPowerOn,
    output logic fanOn,
    output logic intrusionFlag,
    output logic wakeEvent
);
    import pswc_pkg::*;

    localparam int LW = $clog2(LONG_CYC + 1);

    logic swClean, chClean;

    pswc_debounce #(.STABLE_CYC(DEB_CYC)) u_swDeb (
        .clk(clk),
        .rstn(rstn),
        .rawIn(pwrSwitchPressed),
        .cleanOut(swClean)
    );

    pswc_debounce #(.STABLE_CYC(DEB_CYC)) u_chDeb (
        .clk(clk),
        .rstn(rstn),
        .rawIn(chassisClosed),
        .cleanOut(chClean)
    );

    // Press timing
    logic [LW-1:0] hold_q;
    logic [LW-1:0] hold_d;
    logic longDone_q;
    logic longDone_d;
    logic swPrev_q;
    logic swPrev_d;
    logic shortRel;
    logic longHit;

    always_comb begin
        hold_d = hold_q;
        longDone_d = longDone_q;
        swPrev_d = swClean;
        shortRel = 1'b0;
        longHit = 1'b0;
        if (swClean) begin
            if (!longDone_q) begin
                if (hold_q == LW'(LONG_CYC - 1)) begin
                    longHit = 1'b1;
                    longDone_d = 1'b1;
                end else begin
                    hold_d = hold_q + 1'b1;
                end
            end
        end else begin
            if (swPrev_q && !longDone_q) begin
                shortRel = 1'b1;
            end
            hold_d = '0;
            longDone_d = 1'b0;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            hold_q <= '0;
            longDone_q <= 1'b0;
            swPrev_q <= 1'b0;
        end else begin
            hold_q <= hold_d;
            longDone_q <= longDone_d;
            swPrev_q <= swPrev_d;
        end
    end

    // Wake enable for LAN and PME from S5
    logic s5En_q;
    logic s5En_d;

    always_comb begin
        s5En_d = s5WakeEnable;
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            s5En_q <= RST_S5_WAKE_EN;
        end else begin
            s5En_q <= s5En_d;
        end
    end

    // Power state
    pswc_state_t state_q;
    pswc_state_t state_d;
    logic anyWake;

    always_comb begin
        anyWake = 1'b0;
        unique case (state_q)
            PS_S3: anyWake = rtcAlarm | pcieWake | lanWake | pmeWake
                | ps2Wake | serialWake | usbWake;
            PS_S4: anyWake = rtcAlarm | pcieWake | lanWake
                | pmeWake;
            PS_S5: anyWake = rtcAlarm | pcieWake
                | (s5En_q & (lanWake | pmeWake));
            default: anyWake = 1'b0;
        endcase

        state_d = state_q;
        if (longHit && state_q != PS_S5) begin
            state_d = PS_S5;
        end else if (state_q == PS_S0) begin
            if (shortRel) begin
                state_d = PS_S3;
            end else begin
                unique case (osSleepReq)
                    REQ_S3: state_d = PS_S3;
                    REQ_S4: state_d = PS_S4;
                    REQ_S5: state_d = PS_S5;
                    default: state_d = PS_S0;
                endcase
            end
        end else if (shortRel || anyWake) begin
            state_d = PS_S0;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            state_q <= RST_STATE;
        end else begin
            state_q <= state_d;
        end
    end

    // Wake pulse on the way back to S0
    logic wake_q;
    logic wake_d;

    always_comb begin
        wake_d = (state_q != PS_S0) && (state_d == PS_S0);
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            wake_q <= RST_WAKE;
        end else begin
            wake_q <= wake_d;
        end
    end

    // Supply and fan enables follow the next state
    logic fan_q;
    logic fan_d;
    logic pwr_q;
    logic pwr_d;

    always_comb begin
        fan_d = (state_d == PS_S0);
        pwr_d = (state_d == PS_S0);
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            fan_q <= RST_FAN_ON;
            pwr_q <= RST_PWR_ON;
        end else begin
            fan_q <= fan_d;
            pwr_q <= pwr_d;
        end
    end

    // Intrusion latch
    logic intr_q;
    logic intr_d;

    always_comb begin
        // Set wins over clear
        intr_d = chClean | (intr_q & ~intrusionClear);
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            intr_q <= RST_INTR;
        end else begin
            intr_q <= intr_d;
        end
    end

    assign powerState = state_q;
    assign sysPowerOn = pwr_q;
    assign fanOn = fan_q;
    assign intrusionFlag = intr_q;
    assign wakeEvent = wake_q;
endmodule

// ===== pswc_top_monitor.sv
`timescale 1ns/100ps
module pswc_top_monitor
    import pswc_pkg::*;
(
    input wire logic clk,
    input wire logic rstn,
    input wire logic usbWake,
    input wire logic ps2Wake,
    input wire logic rtcAlarm,
    input wire logic intrusionClear,
    input wire pswc_pkg::pswc_req_t osSleepReq,
    input wire pswc_pkg::pswc_state_t powerState,
    input wire logic sysPowerOn,
    input wire logic fanOn,
    input wire logic intrusionFlag,
    input wire logic wakeEvent
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);
    sequence usbInS3;
        powerState == PS_S3 && usbWake;
    endsequence
    chk_fan_state: assert property (fanOn == (powerState == PS_S0))
        else $error("fan");
    chk_usb_wake: assert property (usbInS3 |=> powerState == PS_S0)
        else $error("usb");
    chk_rtc_wake: assert property ((powerState != PS_S0 && rtcAlarm)
        |=> wakeEvent) else $error("rtc");
    chk_ps2_deep: assert property ((powerState == PS_S4 && ps2Wake
        && !rtcAlarm) |=> powerState == PS_S4) else $error("ps2");
    chk_os_sleep: assert property ((powerState == PS_S0
        && osSleepReq == REQ_S3) |=> powerState == PS_S3) else $error("os");
    chk_soft_off: assert property ((powerState == PS_S0
        && osSleepReq == REQ_S5) |=> !sysPowerOn) else $error("off");
    chk_pulse_once: assert property (wakeEvent
        |-> $past(powerState) != PS_S0 ##1 !wakeEvent) else $error("pulse");
    chk_intr_sticky: assert property ((intrusionFlag && !intrusionClear)
        |=> intrusionFlag) else $error("intr");
endmodule
bind pswc_top pswc_top_monitor u_mon (.clk(clk), .rstn(rstn),
    .usbWake(usbWake), .ps2Wake(ps2Wake), .rtcAlarm(rtcAlarm),
    .intrusionClear(intrusionClear), .osSleepReq(osSleepReq),
    .powerState(powerState), .sysPowerOn(sysPowerOn), .fanOn(fanOn),
    .intrusionFlag(intrusionFlag), .wakeEvent(wakeEvent));
